/* File: hw/cibl_exec.sv */
/*
  Executes compact AND, macro expansion, short and extended branches,
  register-zero branches and breakpoint. Assumes fetch offers one word
  with any prefix already joined, holds it while ready is low, and that
  the register file answers reads combinationally.
*/
// Summary of operation
// RULE1: AND of two registers written into first
// RULE2: Select field picks one of eight macros
// RULE3: Parameter fields substituted into native template words
// RULE4: PC held at macro address during expansion
// RULE5: Missing macro raises reserved-instruction exception
// RULE6: Native exceptions reported during expansion
// RULE7: Macro count and interrupt masking fixed here
// RULE8: Macros may not hold loads, stores, branches
// RULE9: Short branch goes to PC+2+offset times two
// RULE10: Extended branch uses 16-bit offset plus four
// RULE11: Zero branch taken only when register zero
// RULE12: Nonzero branch taken only when register nonzero
// RULE13: Extended offset from prefix fields, bits 7:5 zero
// RULE14: All offsets are halfword counts shifted one
// RULE15: Breakpoint always raises breakpoint exception
// RULE16: Untaken branch steps two or four bytes
`timescale 1ns/1ps
`default_nettype none
module cibl_exec
  import cibl_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Fetch side
  input wire cibl_fetch_t fetch,
  output logic ready,
  // Register file
  output logic [2:0] rd_a_index,
  output logic [2:0] rd_b_index,
  input wire logic [31:0] rd_a_data,
  input wire logic [31:0] rd_b_data,
  output cibl_wb_t wb,
  // Program flow
  output logic [31:0] pc,
  output logic redirect,
  // Macro expansion towards the native pipeline
  output logic native_valid,
  output logic [31:0] native_word,
  input wire logic native_exc,
  output logic irq_mask,
  // Exceptions
  output cibl_exc_t exc,
  output logic [31:0] exc_pc
);
  typedef enum logic [1:0] {
    CIBL_IDLE = 2'b00,
    CIBL_FETCH = 2'b01,
    CIBL_ISSUE = 2'b10
  } cibl_state_t;

  cibl_state_t state;
  logic [1:0] step;
  logic [2:0] sel;
  logic [24:0] params;
  logic [31:0] tmpl;
  logic [15:0] w;
  logic [4:0] op;
  logic [31:0] seq;
  logic [31:0] target;
  logic [31:0] next_pc;
  logic take;
  logic ext_ok;
  logic go;

  // Halfword offset: sign extend, then double
  function automatic logic [31:0] half_off(input logic [15:0] o,
                                           input int bits);
    logic [31:0] s;
    s = 32'($signed(o << (16 - bits))) >>> (16 - bits);
    return {s[30:0], 1'b0};
  endfunction

  assign w = fetch.word;
  assign op = w[15:11];
  assign go = fetch.valid && ready;
  assign ready = (state == CIBL_IDLE);
  assign rd_a_index = w[10:8];
  assign rd_b_index = w[7:5];
  assign seq = fetch.pc + (fetch.extended ? STEP_LONG : STEP_SHORT); // [RULE16]
  assign ext_ok = !fetch.extended || (w[7:5] == EXT_MID_ZERO); // [RULE13]

  always_comb begin
    target = seq;
    take = 1'b0;
    if (op == OP_BRANCH) begin
      take = 1'b1; // [RULE9]
      target = fetch.extended ?
        seq + half_off({fetch.prefix[4:0], fetch.prefix[10:5], w[4:0]},
                       16) : // [RULE10] [RULE14]
        seq + half_off({5'h00, w[10:0]}, 11); // [RULE9] [RULE14]
    end else if (op == OP_BR_ZERO || op == OP_BR_NONZERO) begin
      take = (op == OP_BR_ZERO) ? (rd_a_data == 32'h0000_0000) :
             (rd_a_data != 32'h0000_0000); // [RULE11] [RULE12]
      target = fetch.extended ?
        seq + half_off({fetch.prefix[4:0], fetch.prefix[10:5], w[4:0]},
                       16) : // [RULE13] [RULE14]
        seq + half_off({8'h00, w[7:0]}, 8);
    end
    next_pc = take ? target : seq; // [RULE16]
  end

  // Program counter
  always_ff @(posedge mclk) begin
    if (rst) begin
      pc <= PC_RESET;
      redirect <= 1'b0;
    end else begin
      redirect <= 1'b0;
      if (go && state == CIBL_IDLE && op != OP_MACRO &&
          !(op == OP_REG_REG && w[4:0] == FN_BREAK) && ext_ok) begin
        pc <= next_pc;
        redirect <= take;
      end else if (go) begin
        pc <= fetch.pc; // [RULE4]
      end
    end
  end

  // Register writeback
  always_ff @(posedge mclk) begin
    if (rst) begin
      wb <= '0;
    end else begin
      wb.en <= go && op == OP_REG_REG && w[4:0] == FN_AND;
      wb.index <= w[10:8];
      wb.data <= rd_a_data & rd_b_data; // [RULE1]
    end
  end

  // Exceptions
  always_ff @(posedge mclk) begin
    if (rst) begin
      exc <= CIBL_EXC_NONE;
      exc_pc <= PC_RESET;
    end else begin
      exc <= CIBL_EXC_NONE;
      if (go && op == OP_REG_REG && w[4:0] == FN_BREAK) begin
        exc <= CIBL_EXC_BREAK; // [RULE15]
        exc_pc <= fetch.pc;
      end else if (go && op == OP_MACRO && !MACRO_PRESENT[w[10:8]]) begin
        exc <= CIBL_EXC_RESERVED; // [RULE5]
        exc_pc <= fetch.pc;
      end else if (state == CIBL_ISSUE && native_exc) begin
        exc <= CIBL_EXC_NATIVE; // [RULE6]
        exc_pc <= pc; // [RULE4]
      end
    end
  end

  // Macro sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= CIBL_IDLE;
      step <= 2'h0;
      sel <= 3'h0;
      params <= '0;
    end else begin
      unique case (state)
        CIBL_IDLE: begin
          if (go && op == OP_MACRO && MACRO_PRESENT[w[10:8]]) begin
            sel <= w[10:8]; // [RULE2]
            params <= {fetch.prefix, w[7:0], 6'h00};
            step <= 2'h0;
            state <= CIBL_FETCH;
          end
        end
        CIBL_FETCH: begin
          state <= CIBL_ISSUE;
        end
        CIBL_ISSUE: begin
          if (native_exc || step == 2'(MACRO_LEN - 1)) begin
            state <= CIBL_IDLE; // [RULE6]
          end else begin
            step <= step + 2'h1;
            state <= CIBL_FETCH;
          end
        end
      endcase
    end
  end

  cibl_macro_rom u_rom (
    .mclk(mclk),
    .addr({sel, step}),
    .data(tmpl)
  ); // [RULE2]

  // Substitute p0..p4 into rs, rt, rd, sa and low immediate
  always_comb begin
    native_word = tmpl;
    native_word[25:21] = tmpl[25:21] | params[24:20]; // [RULE3]
    native_word[20:16] = tmpl[20:16] | params[19:15];
    native_word[15:11] = tmpl[15:11] | params[14:10];
    native_word[10:6] = tmpl[10:6] | params[9:5];
    native_word[4:0] = tmpl[4:0] | params[4:0];
  end

  assign native_valid = (state == CIBL_ISSUE); // [RULE8]
  assign irq_mask = MACRO_MASK_IRQ && (state != CIBL_IDLE); // [RULE7]
endmodule
`default_nettype wire

/* File: hw/cibl_pkg.sv */
/*
  Shared constants and carrier types for the compact-mode branch, logic,
  macro and breakpoint executor.
  Assumes a 32-bit datapath and 16-bit compact instruction words.
*/
package cibl_pkg;
  localparam logic [4:0] OP_REG_REG = 5'h1D;
  localparam logic [4:0] FN_AND = 5'h0C;
  localparam logic [4:0] OP_EXTEND = 5'h1E;
  localparam logic [4:0] OP_BRANCH = 5'h02;
  localparam logic [4:0] OP_BR_ZERO = 5'h04;
  localparam logic [4:0] OP_BR_NONZERO = 5'h05;
  localparam logic [4:0] OP_MACRO = 5'h1C;
  localparam logic [4:0] FN_BREAK = 5'h05;
  localparam logic [2:0] EXT_MID_ZERO = 3'h0;
  localparam logic [31:0] STEP_SHORT = 32'h0000_0002;
  localparam logic [31:0] STEP_LONG = 32'h0000_0004;
  localparam int MACRO_COUNT = 8;
  localparam int MACRO_LEN = 4;
  localparam int ROM_WORDS = MACRO_COUNT * MACRO_LEN;
  localparam logic [7:0] MACRO_PRESENT = 8'h03;
  localparam logic MACRO_MASK_IRQ = 1'b1;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    CIBL_EXC_NONE = 2'b00,
    CIBL_EXC_RESERVED = 2'b01,
    CIBL_EXC_BREAK = 2'b10,
    CIBL_EXC_NATIVE = 2'b11
  } cibl_exc_t;

  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic [15:0] word;
    logic extended;
    logic [10:0] prefix;
  } cibl_fetch_t;

  typedef struct packed {
    logic en;
    logic [2:0] index;
    logic [31:0] data;
  } cibl_wb_t;
endpackage

/* File: hw/cibl_macro_rom.sv */
/*
  Macro template store: eight macros of four native words each, with a
  registered read port. Assumes one read per cycle on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module cibl_macro_rom
  import cibl_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Read port
  input wire logic [4:0] addr,
  output logic [31:0] data
);
  logic [31:0] rom [ROM_WORDS];

  // Templates: p0..p4 go into fields rs, rt, rd, sa and low immediate
  initial begin
    for (int i = 0; i < ROM_WORDS; i++) begin
      rom[i] = 32'h0000_0000;
    end
    rom[0] = 32'h0000_0021;
    rom[1] = 32'h0000_0024;
    rom[4] = 32'h3400_0000;
    rom[5] = 32'h0000_0025;
  end

  always_ff @(posedge mclk) begin
    data <= rom[addr];
  end
endmodule
`default_nettype wire

/* File: verif/cibl_monitor.sv */
/* Checker for cibl_exec: branch targets, write-back, traps, macro hold.
   Assumes one mclk domain and synchronous active-high rst. */
`timescale 1ns/1ps
`default_nettype none
module cibl_monitor
  import cibl_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Watched ports
  input wire cibl_fetch_t fetch,
  input wire logic ready,
  input wire logic [31:0] rd_a_data,
  input wire logic [31:0] rd_b_data,
  input wire cibl_wb_t wb,
  input wire logic [31:0] pc,
  input wire logic redirect,
  input wire logic native_valid,
  input wire logic native_exc,
  input wire logic irq_mask,
  input wire cibl_exc_t exc
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire tk = fetch.valid && ready;
  wire [4:0] op = fetch.word[15:11];
  wire [2:0] rx = fetch.word[10:8];
  wire ok = !fetch.extended || fetch.word[7:5] == EXT_MID_ZERO;
  wire [15:0] el = {fetch.prefix[4:0], fetch.prefix[10:5], fetch.word[4:0]};
  wire [31:0] nx = fetch.pc + (fetch.extended ? STEP_LONG : STEP_SHORT);
  wire [31:0] off = fetch.extended ? {{15{el[15]}}, el, 1'b0} :
    op == OP_BRANCH ? {{20{fetch.word[10]}}, fetch.word[10:0], 1'b0} :
    {{23{fetch.word[7]}}, fetch.word[7:0], 1'b0};
  wire [31:0] tgt = nx + off;
  wire cnd = op == OP_BR_ZERO || op == OP_BR_NONZERO;
  wire [31:0] ct = ((rd_a_data == 32'h0) ^ op[0]) ? tgt : nx;
  wire [31:0] andv = rd_a_data & rd_b_data;
  wire reg_op = tk && op == OP_REG_REG;
  wire mac = tk && op == OP_MACRO;
  br_uncond_a: assert property (tk && ok && op == OP_BRANCH
    |=> redirect && pc == $past(tgt)) else $error("bad branch target");
  br_cond_a: assert property (tk && ok && cnd
    |=> pc == $past(ct)) else $error("bad conditional pc");
  ext_refuse_a: assert property (tk && !ok && cnd
    |=> pc == $past(fetch.pc) && !redirect)
    else $error("pc moved on bad extended word");
  and_wb_a: assert property (reg_op && fetch.word[4:0] == FN_AND
    |=> wb.en && wb.index == $past(rx) && wb.data == $past(andv))
    else $error("bad and write-back");
  brk_exc_a: assert property (reg_op && fetch.word[4:0] == FN_BREAK
    |=> exc == CIBL_EXC_BREAK) else $error("no breakpoint trap");
  macro_rsv_a: assert property (mac && !MACRO_PRESENT[rx]
    |=> exc == CIBL_EXC_RESERVED && !wb.en) else $error("no reserved trap");
  macro_busy_a: assert property (mac && MACRO_PRESENT[rx]
    |=> (!ready && irq_mask)[*2]) else $error("macro not held");
  macro_full_a: assert property (mac && MACRO_PRESENT[rx]
    ##2 !native_exc |=> (!ready && irq_mask)[*2])
    else $error("macro ended early");
  native_abort_a: assert property (native_valid && native_exc
    |=> ready && exc == CIBL_EXC_NATIVE) else $error("native fault lost");
  issue_hold_a: assert property (native_valid |-> $stable(pc))
    else $error("pc moved during macro");
  cover property (mac && MACRO_PRESENT[rx]);
  cover property (redirect);
  cover property (exc == CIBL_EXC_NATIVE);
endmodule
bind cibl_exec cibl_monitor u_mon (.mclk(mclk), .rst(rst), .fetch(fetch),
  .ready(ready), .rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .wb(wb),
  .pc(pc), .redirect(redirect), .native_valid(native_valid),
  .native_exc(native_exc), .irq_mask(irq_mask), .exc(exc));
`default_nettype wire

/* File: verif/cibl_exec_tb.sv */
/* Directed bench for cibl_exec: one task for branches, one for AND and traps, one for macros.
   Assumes the register file is played by rd_a_data and rd_b_data. */
`timescale 1ns/1ps
`default_nettype none
module cibl_exec_tb
  import cibl_pkg::*;
;
  logic mclk, rst, ready, redirect, native_valid, native_exc, irq_mask;
  cibl_fetch_t fetch;
  cibl_wb_t wb;
  cibl_exc_t exc;
  logic [2:0] ia, ib;
  logic [31:0] rd_a_data, rd_b_data, pc, native_word, exc_pc;
  int bad_count, checked;
  cibl_exec DUT (.mclk(mclk), .rst(rst), .fetch(fetch), .ready(ready),
    .rd_a_index(ia), .rd_b_index(ib), .rd_a_data(rd_a_data),
    .rd_b_data(rd_b_data), .wb(wb), .pc(pc), .redirect(redirect),
    .native_valid(native_valid), .native_word(native_word),
    .native_exc(native_exc), .irq_mask(irq_mask), .exc(exc), .exc_pc(exc_pc));
  always #5 mclk = ~mclk;
  task automatic close_out();
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Offer one word; valid stays up until the next word replaces it
  task automatic go(input logic [15:0] w, input logic e, input logic [10:0] p);
    int n;
    n = 0;
    fetch = {1'b1, 32'h100, w, e, p};
    while (ready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 20) begin
      chk(ready, 32'h1);
      close_out();
    end else begin
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic t_branch();
    int k;
    go({OP_BRANCH, 11'h7FF}, 1'b0, 11'h0);
    chk(pc, 32'h100);
    chk(redirect, 32'h1);
    go({OP_BRANCH, 11'h001}, 1'b1, 11'h010);
    chk(pc, 32'hFFFF_0106);
    for (k = 0; k < 4; k++) begin
      rd_a_data = k[0] ? 32'h5 : 32'h0;
      go({k[1] ? OP_BR_NONZERO : OP_BR_ZERO, 3'h1, 8'h10}, 1'b0, 11'h0);
      chk(pc, (k[1] == k[0]) ? 32'h122 : 32'h102);
      chk(redirect, k[1] == k[0]);
    end
    rd_a_data = 32'h0;
    go({OP_BR_ZERO, 3'h1, 3'h0, 5'h03}, 1'b1, 11'h0);
    chk(pc, 32'h10A);
    rd_a_data = 32'h7;
    go({OP_BR_ZERO, 3'h1, 3'h0, 5'h03}, 1'b1, 11'h0);
    chk(pc, 32'h104);
    go({OP_BR_NONZERO, 3'h1, 3'h2, 5'h03}, 1'b1, 11'h0);
    chk(pc, 32'h100);
  endtask
  task automatic t_logic();
    rd_a_data = 32'hF0F0_00FF;
    rd_b_data = 32'h0FF0_0F0F;
    go({OP_REG_REG, 3'h2, 3'h3, FN_AND}, 1'b0, 11'h0);
    chk({wb.en, wb.index}, 4'hA);
    chk({ia, ib}, 6'h13);
    chk(wb.data, 32'h00F0_000F);
    go({OP_REG_REG, 6'h3F, FN_BREAK}, 1'b0, 11'h0);
    chk(exc, CIBL_EXC_BREAK);
    chk(exc_pc, 32'h100);
    go({OP_MACRO, 3'h2, 8'h00}, 1'b0, 11'h0);
    chk(exc, CIBL_EXC_RESERVED);
  endtask
  // Run a present macro, optionally faulting its first native word
  task automatic t_macro(input logic [2:0] s, input logic f, input int nv,
                         input logic [31:0] ew);
    int n, cnt;
    logic hit, msk;
    logic [31:0] fw;
    n = 0;
    cnt = 0;
    fw = 32'h0;
    hit = 1'b0;
    msk = 1'b0;
    go({OP_MACRO, s, 8'h5A}, 1'b0, 11'h2A5);
    while (ready !== 1'b1 && n < 20) begin
      if (native_valid === 1'b1 && cnt == 0) fw = native_word;
      if (native_valid === 1'b1) cnt++;
      msk = msk | irq_mask;
      native_exc = f && native_valid === 1'b1;
      @(posedge mclk);
      #1;
      n++;
      hit = hit | (exc === CIBL_EXC_NATIVE);
    end
    native_exc = 1'b0;
    chk(n < 20, 1);
    if (n >= 20) begin
      close_out();
    end else begin
      chk(pc, 32'h100);
      chk(cnt, nv);
      chk(fw, ew);
      chk({hit, msk}, {f, MACRO_MASK_IRQ});
    end
  endtask
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    fetch = '0;
    rd_a_data = 32'h0;
    rd_b_data = 32'h0;
    native_exc = 1'b0;
    bad_count = 0;
    checked = 0;
    repeat (12) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_branch();
    t_logic();
    t_macro(3'h0, 1'b0, MACRO_LEN, 32'h0152_AD21);
    t_macro(3'h1, 1'b1, 1, 32'h3552_AD00);
    close_out();
  end
endmodule
`default_nettype wire
